// File: test/sbst_ctl_model.sv
`timescale 1ns/10ps
`default_nettype none
module sbst_ctl_model
  import sbst_pkg::*;
(
  input  wire logic       clk_sys,
  input  wire logic       tdo,
  output var  sbst_pins_t pins
);
  // 80 ns per phase keeps the link clock far under its ceiling
  localparam int HALF = 8;

  // Link clock stands low between frames; data input rests at pull-up, mode select stays at its last value
  initial pins = '{tck: 1'b0, tms: 1'b1, tdi: 1'b1};

  task automatic tick(input logic tms_v, input logic tdi_v,
                      output logic tdo_v);
    @(posedge clk_sys);
    pins.tms <= tms_v;
    pins.tdi <= tdi_v;
    repeat (HALF - 1) @(posedge clk_sys);
    tdo_v = tdo;
    pins.tck <= 1'b1;
    repeat (HALF) @(posedge clk_sys);
    pins.tck <= 1'b0;
    pins.tdi <= 1'b1;
  endtask : tick

  task automatic go_shift(input logic to_ir);
    logic b;
    tick(1'b0, 1'b1, b);
    tick(1'b1, 1'b1, b);
    if (to_ir)
      tick(1'b1, 1'b1, b);
    tick(1'b0, 1'b1, b);
    tick(1'b0, 1'b1, b);
  endtask : go_shift

  // LSB leaves first; the last bit also leaves the shift state
  task automatic shift(input int n, input logic [95:0] din,
                       output logic [95:0] dout);
    logic b;
    dout = '0;
    for (int i = 0; i < n; i++)
    begin
      tick(i == n - 1, din[i], b);
      dout[i] = b;
    end
  endtask : shift

  task automatic finish();
    logic b;
    tick(1'b1, 1'b1, b);
    tick(1'b0, 1'b1, b);
  endtask : finish

  task automatic tms_reset();
    logic b;
    repeat (5) tick(1'b1, 1'b1, b);
    tick(1'b0, 1'b1, b);
  endtask : tms_reset
endmodule : sbst_ctl_model
`default_nettype wire

// File: test/testbench.sv
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, exp, got) \
  begin \
    samples_checked++; \
    if ((got) !== (exp)) \
    begin \
      mismatches++; \
      $display("[ERR] %s expected %h seen %h", nm, exp, got); \
    end \
  end
module testbench
  import sbst_pkg::*;
();
  localparam logic [31:0] ID = 32'h5A3C_0F01; // Arbitrary value
  localparam logic [87:0] P  = {22{4'h9}};
  localparam logic [87:0] Q  = {22{4'h6}};
  logic                clk_sys, rst_n, tdo, tdo_oe, sys_out_oe;
  logic                pin_out_oe, own, mid;
  logic [SBST_NPIN-1:0] pin_in, sys_out, pin_out;
  sbst_pins_t          pins;
  int                  mismatches, samples_checked;
  logic [95:0]         d;

  sbst_tap #(.ID_WORD(ID)) DUT (.clk_sys(clk_sys), .rst_n(rst_n),
    .pins(pins), .tdo(tdo), .tdo_oe(tdo_oe), .pin_in(pin_in),
    .sys_out(sys_out), .sys_out_oe(sys_out_oe), .pin_out(pin_out),
    .pin_out_oe(pin_out_oe), .scan_owns_pins(own));
  sbst_ctl_model ctl (.clk_sys(clk_sys), .tdo(tdo), .pins(pins));

  initial
  begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  // Only functional codes are ever loaded, four of the five; identification comes from reset
  task automatic ir(input logic [2:0] code);
    ctl.go_shift(1'b1);
    ctl.shift(3, {93'h0, code}, d);
    mid = own;
    `CHK("oe in shift", 1'b1, tdo_oe)
    ctl.finish();
    `CHK("ir capture", 2'h1, d[1:0])
    `CHK("oe idle", 1'b0, tdo_oe)
  endtask : ir

  task automatic dr(input int n, input logic [95:0] din);
    ctl.go_shift(1'b0);
    ctl.shift(n, din, d);
    ctl.finish();
  endtask : dr

  task automatic t_id();
    dr(32, 96'h0);
    `CHK("id word", ID, d[31:0])
    `CHK("idle oe", sys_out_oe, pin_out_oe)
    $display("test id done");
  endtask : t_id

  task automatic t_byp();
    ir(SBST_IR_BYPASS);
    dr(8, 96'hA5);
    `CHK("bypass", 8'h4A, d[7:0])
    $display("test bypass done");
  endtask : t_byp

  task automatic t_samp();
    ir(SBST_IR_SAMPLE);
    dr(89, {8'h0, 1'b0, Q});
    `CHK("sampled pins", P, d[87:0])
    `CHK("oe cell", 1'b1, d[88])
    `CHK("pins free", sys_out, pin_out)
    $display("test sample done");
  endtask : t_samp

  task automatic t_ext();
    ir(SBST_IR_EXTEST);
    `CHK("old instr", 1'b0, mid)
    `CHK("ext owns", 1'b1, own)
    `CHK("preload out", Q, pin_out)
    `CHK("oe low", 1'b0, pin_out_oe)
    dr(89, {8'h0, 1'b1, Q});
    `CHK("oe capt", 1'b0, d[88])
    `CHK("oe high", 1'b1, pin_out_oe)
    dr(89, {8'h0, 1'b0, Q});
    `CHK("oe low again", 1'b0, pin_out_oe)
    $display("test extest done");
  endtask : t_ext

  task automatic t_rst();
    ctl.tms_reset();
    `CHK("rst owns", 1'b0, own)
    dr(32, 96'h0);
    `CHK("rst id", ID, d[31:0])
    ir(SBST_IR_EXTEST);
    `CHK("oe preset", 1'b1, pin_out_oe)
    $display("test reset done");
  endtask : t_rst

  task automatic t_sampz();
    ir(SBST_IR_SAMPZ);
    `CHK("z oe", 1'b0, pin_out_oe)
    dr(89, 96'h0);
    `CHK("z chain", P, d[87:0])
    `CHK("z oe held", 1'b0, pin_out_oe)
    $display("test samplez done");
  endtask : t_sampz

  task automatic final_report();
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : final_report

  initial
  begin
    mismatches = 0;
    samples_checked = 0;
    rst_n = 1'b0;
    pin_in = '0;
    sys_out = '0;
    sys_out_oe = 1'b0;
    repeat (4) @(posedge clk_sys);
    rst_n <= 1'b1;
    pin_in <= P;
    sys_out <= {22{4'h3}};
    sys_out_oe <= 1'b1;
    repeat (4) @(posedge clk_sys);
    t_id();
    t_byp();
    t_samp();
    t_ext();
    t_rst();
    t_sampz();
    final_report();
  end
endmodule : testbench
`default_nettype wire

// File: verilog/sbst_fsm.sv
`timescale 1ns/10ps
`default_nettype none
module sbst_fsm
  import sbst_pkg::*;
(
  input  wire logic      clk_sys,
  input  wire logic      rst_l,
  input  wire logic      step,
  input  wire logic      tms,
  output var sbst_tap_t  state
);
  sbst_tap_t state_r;
  sbst_tap_t state_nxt;

  // Next state of the sixteen-state controller, moved on each rise
  always_comb
  begin
    state_nxt = state_r;
    if (step)
    begin
      case (state_r)
        TLR:     state_nxt = tms ? TLR    : RTI;
        RTI:     state_nxt = tms ? SEL_DR : RTI;
        SEL_DR:  state_nxt = tms ? SEL_IR : CAP_DR;
        CAP_DR:  state_nxt = tms ? EX1_DR : SH_DR;
        SH_DR:   state_nxt = tms ? EX1_DR : SH_DR;
        EX1_DR:  state_nxt = tms ? UPD_DR : PA_DR;
        PA_DR:   state_nxt = tms ? EX2_DR : PA_DR;
        EX2_DR:  state_nxt = tms ? UPD_DR : SH_DR;
        UPD_DR:  state_nxt = tms ? SEL_DR : RTI;
        SEL_IR:  state_nxt = tms ? TLR    : CAP_IR;
        CAP_IR:  state_nxt = tms ? EX1_IR : SH_IR;
        SH_IR:   state_nxt = tms ? EX1_IR : SH_IR;
        EX1_IR:  state_nxt = tms ? UPD_IR : PA_IR;
        PA_IR:   state_nxt = tms ? EX2_IR : PA_IR;
        EX2_IR:  state_nxt = tms ? UPD_IR : SH_IR;
        UPD_IR:  state_nxt = tms ? SEL_DR : RTI;
        default: state_nxt = TLR;
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge rst_l)
  begin
    if (!rst_l)
      state_r <= TLR;
    else
      state_r <= state_nxt;
  end

  assign state = state_r;

  // Five rises with mode select high always reach reset
  localparam logic [2:0] RST_EDGES = 3'(SBST_RST_TMS_EDGES);
  logic [2:0] hi_cnt_r;
  sequence five_high_s;
    hi_cnt_r == RST_EDGES;
  endsequence
  always_ff @(posedge clk_sys or negedge rst_l)
  begin
    if (!rst_l)
      hi_cnt_r <= 3'h0;
    else if (step)
      hi_cnt_r <= !tms ? 3'h0
                : (hi_cnt_r == RST_EDGES ? RST_EDGES : hi_cnt_r + 3'h1);
  end
  five_reset_a: assert property (
    @(posedge clk_sys) disable iff (!rst_l)
    five_high_s |-> state_r == TLR)
    else $error("five high rises did not reach reset");
  cap_shift_a: assert property (
    @(posedge clk_sys) disable iff (!rst_l)
    (state_r == CAP_DR && step && !tms) |=> state_r == SH_DR)
    else $error("capture did not move to shift");
endmodule : sbst_fsm
`default_nettype wire

// File: verilog/sbst_pkg.sv
package sbst_pkg;

  localparam int SBST_IR_W   = 3;
  localparam int SBST_ID_W   = 32;
  localparam int SBST_BSR_W  = 89;
  localparam int SBST_NPIN   = 88;
  localparam int SBST_OE_BIT = 88;
  localparam int SBST_RST_TMS_EDGES = 5;

  localparam logic [2:0] SBST_IR_EXTEST  = 3'h0;
  localparam logic [2:0] SBST_IR_IDCODE  = 3'h1;
  localparam logic [2:0] SBST_IR_SAMPZ   = 3'h2;
  localparam logic [2:0] SBST_IR_SAMPLE  = 3'h4;
  localparam logic [2:0] SBST_IR_BYPASS  = 3'h7;
  localparam logic [1:0] SBST_IR_CAPT    = 2'h1;
  localparam logic       SBST_OE_RESET   = 1'b1;
  localparam logic       SBST_TDO_RESET  = 1'b0;

  typedef enum logic [3:0] {
    TLR, RTI, SEL_DR, CAP_DR, SH_DR, EX1_DR, PA_DR, EX2_DR, UPD_DR,
    SEL_IR, CAP_IR, SH_IR, EX1_IR, PA_IR, EX2_IR, UPD_IR
  } sbst_tap_t;

  typedef struct packed {
    logic tck;
    logic tms;
    logic tdi;
  } sbst_pins_t;

endpackage : sbst_pkg

// File: verilog/sbst_tap.sv
// What this block does
// - Identification instruction loads a fixed 32-bit word in Capture-DR.
// - That word shifts out on test data output during Shift-DR.
// - Three-bit instruction register; five encodings are functional.
// - Instruction register sits in the serial path during Shift-IR.
// - New instruction takes effect only at Update-IR.
// - Identification instruction is current at power-up and test-logic-reset.
// - Sample-high-Z selects boundary register and floats the output bus.
// - Sample/preload captures all pin values in Capture-DR.
// - After capture the boundary register shifts between data in and out.
// - Preload latches shifted pattern into boundary parallel outputs.
// - Captured bits shift out while preload bits shift in.
// - Bypass instruction puts the one-bit bypass register in Shift-DR path.
// - External test drives preloaded values onto system outputs.
// - Boundary register has an output-enable cell at bit 89, no pin.
// - Under external test, latched high enables outputs, low floats them.
// - Output-enable cell latch loads shifted value during Update-DR under external test or sample/preload.
// - Output-enable latch presets high at power-up and test-logic-reset.
// - Mode select high for five rising edges resets the test logic.
// - Encodings 000,001,010,100,111 functional; 011,101,110 reserved.
// - Capture-IR loads 01 into the two low instruction bits.
// - Inputs taken on rising edges, output on falling; MSB in, LSB out.
`timescale 1ns/10ps
`default_nettype none
module sbst_tap
  import sbst_pkg::*;
#(
  parameter logic [31:0] ID_WORD = 32'h0ABC_1235 // Arbitrary neutral value
)
(
  input  wire logic                  clk_sys,
  input  wire logic                  rst_n,
  input  wire sbst_pins_t            pins,
  output logic                       tdo,
  output logic                       tdo_oe,
  input  wire logic [SBST_NPIN-1:0]  pin_in,
  input  wire logic [SBST_NPIN-1:0]  sys_out,
  input  wire logic                  sys_out_oe,
  output logic      [SBST_NPIN-1:0]  pin_out,
  output logic                       pin_out_oe,
  output logic                       scan_owns_pins
);
  typedef struct packed {
    sbst_pins_t                 s1;
    sbst_pins_t                 s2;
    logic                       tck_d;
    logic [SBST_IR_W-1:0]       ir_sh;
    logic [SBST_IR_W-1:0]       ir;
    logic [SBST_ID_W-1:0]       id_sh;
    logic                       byp;
    logic [SBST_BSR_W-1:0]      bsr_sh;
    logic [SBST_BSR_W-1:0]      bsr_up;
    logic                       tdo;
    logic                       tdo_oe;
  } sbst_state_t;

  logic        rst_s1_r;
  logic        rst_l;
  sbst_state_t st_r;
  sbst_state_t st_nxt;
  sbst_tap_t   tap;
  logic        rise;
  logic        fall;
  logic        ser_bit;
  logic        is_bsr;

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rst_s1_r <= 1'b0;
      rst_l    <= 1'b0;
    end
    else
    begin
      rst_s1_r <= 1'b1;
      rst_l    <= rst_s1_r;
    end
  end

  // Edges come from the second synchroniser stage only
  assign rise = st_r.s2.tck & ~st_r.tck_d;
  assign fall = ~st_r.s2.tck & st_r.tck_d;

  sbst_fsm u_fsm (
    .clk_sys (clk_sys),
    .rst_l   (rst_l),
    .step    (rise),
    .tms     (st_r.s2.tms),
    .state   (tap)
  );

  // Reserved codes fall to bypass so the chain stays one bit long
  assign is_bsr = (st_r.ir == SBST_IR_EXTEST) || (st_r.ir == SBST_IR_SAMPZ)
                  || (st_r.ir == SBST_IR_SAMPLE);

  always_comb
  begin
    if (tap == SH_IR)
      ser_bit = st_r.ir_sh[0];
    else if (st_r.ir == SBST_IR_IDCODE)
      ser_bit = st_r.id_sh[0];
    else if (is_bsr)
      ser_bit = st_r.bsr_sh[0];
    else
      ser_bit = st_r.byp;
  end

  always_comb
  begin
    st_nxt       = st_r;
    st_nxt.s1    = pins;
    st_nxt.s2    = st_r.s1;
    st_nxt.tck_d = st_r.s2.tck;
    if (rise)
    begin
      case (tap)
        CAP_IR:
          st_nxt.ir_sh = {1'b0, SBST_IR_CAPT};
        SH_IR:
          st_nxt.ir_sh = {st_r.s2.tdi, st_r.ir_sh[SBST_IR_W-1:1]};
        UPD_IR:
          st_nxt.ir = st_r.ir_sh;
        CAP_DR:
        begin
          st_nxt.id_sh = ID_WORD;
          st_nxt.byp   = 1'b0;
          // Captured pins may be mid-transition; the clock pin bit is
          // best ignored by the controller.
          st_nxt.bsr_sh = {st_r.bsr_up[SBST_OE_BIT], pin_in};
        end
        SH_DR:
        begin
          st_nxt.id_sh  = {st_r.s2.tdi, st_r.id_sh[SBST_ID_W-1:1]};
          st_nxt.byp    = st_r.s2.tdi;
          if (is_bsr)
            st_nxt.bsr_sh = {st_r.s2.tdi,
                             st_r.bsr_sh[SBST_BSR_W-1:1]};
        end
        UPD_DR:
          if (is_bsr && st_r.ir != SBST_IR_SAMPZ)
            st_nxt.bsr_up = st_r.bsr_sh;
        default:
        begin
        end
      endcase
    end
    // Held while in reset state, so an old instruction never drives pins
    if (tap == TLR)
    begin
      st_nxt.ir                  = SBST_IR_IDCODE;
      st_nxt.bsr_up[SBST_OE_BIT] = SBST_OE_RESET;
    end
    if (fall)
    begin
      st_nxt.tdo    = ser_bit;
      st_nxt.tdo_oe = (tap == SH_IR) || (tap == SH_DR);
    end
  end

  always_ff @(posedge clk_sys or negedge rst_l)
  begin
    if (!rst_l)
    begin
      st_r        <= '0;
      st_r.ir     <= SBST_IR_IDCODE;
      st_r.bsr_up[SBST_OE_BIT] <= SBST_OE_RESET;
      st_r.tdo    <= SBST_TDO_RESET;
    end
    else
      st_r <= st_nxt;
  end

  assign tdo    = st_r.tdo;
  assign tdo_oe = st_r.tdo_oe;

  // Bit 89 (index 88) has no pin and only gates the output bus
  always_comb
  begin
    scan_owns_pins = (st_r.ir == SBST_IR_EXTEST);
    if (st_r.ir == SBST_IR_EXTEST)
    begin
      pin_out    = st_r.bsr_up[SBST_NPIN-1:0];
      pin_out_oe = st_r.bsr_up[SBST_OE_BIT];
    end
    else if (st_r.ir == SBST_IR_SAMPZ)
    begin
      pin_out    = sys_out;
      pin_out_oe = 1'b0;
    end
    else
    begin
      pin_out    = sys_out;
      pin_out_oe = sys_out_oe;
    end
  end

  // Named steps of the scan walk, shared by the checks below
  sequence upd_ir_s;
    rise && tap == UPD_IR;
  endsequence
  sequence cap_dr_s;
    rise && tap == CAP_DR;
  endsequence
  sequence sh_dr_s;
    rise && tap == SH_DR;
  endsequence
  sequence upd_dr_s;
    rise && tap == UPD_DR;
  endsequence
  sequence sh_ir_s;
    rise && tap == SH_IR;
  endsequence

  ir_update_a: assert property (
    @(posedge clk_sys) disable iff (!rst_l)
    upd_ir_s |=> st_r.ir == $past(st_r.ir_sh))
    else $error("instruction not updated at Update-IR");

  ir_hold_a: assert property (
    @(posedge clk_sys) disable iff (!rst_l)
    !(rise && tap == UPD_IR) && tap != TLR |=> $stable(st_r.ir))
    else $error("instruction changed outside Update-IR");

  tlr_idcode_a: assert property (
    @(posedge clk_sys) disable iff (!rst_l)
    tap == TLR |=> st_r.ir == SBST_IR_IDCODE && st_r.bsr_up[SBST_OE_BIT])
    else $error("reset did not restore instruction and enable cell");

  id_cap_a: assert property (
    @(posedge clk_sys) disable iff (!rst_l)
    cap_dr_s |=> st_r.id_sh == ID_WORD)
    else $error("identification word not captured");

  ir_cap_a: assert property (
    @(posedge clk_sys) disable iff (!rst_l)
    (rise && tap == CAP_IR) |=> st_r.ir_sh[1:0] == SBST_IR_CAPT)
    else $error("capture pattern wrong");

  sampz_float_a: assert property (
    @(posedge clk_sys) disable iff (!rst_l)
    st_r.ir == SBST_IR_SAMPZ |-> !pin_out_oe)
    else $error("output bus driven under sample high-Z");

  extest_oe_a: assert property (
    @(posedge clk_sys) disable iff (!rst_l)
    st_r.ir == SBST_IR_EXTEST |-> pin_out_oe == st_r.bsr_up[SBST_OE_BIT]
      && pin_out == st_r.bsr_up[SBST_NPIN-1:0])
    else $error("external test output wrong");

  tdo_fall_a: assert property (
    @(posedge clk_sys) disable iff (!rst_l)
    !fall |=> $stable(st_r.tdo))
    else $error("data output changed off a falling edge");

  bypass_a: assert property (
    @(posedge clk_sys) disable iff (!rst_l)
    (fall && tap == SH_DR && st_r.ir == SBST_IR_BYPASS)
      |=> st_r.tdo == $past(st_r.byp))
    else $error("bypass bit not on output");

  ir_shift_a: assert property (
    @(posedge clk_sys) disable iff (!rst_l)
    sh_ir_s |=> st_r.ir_sh == {$past(st_r.s2.tdi),
      $past(st_r.ir_sh[SBST_IR_W-1:1])})
    else $error("instruction bits did not shift");

  ir_path_a: assert property (
    @(posedge clk_sys) disable iff (!rst_l)
    (fall && tap == SH_IR) |=> st_r.tdo == $past(st_r.ir_sh[0]))
    else $error("instruction register not on data output");

  id_path_a: assert property (
    @(posedge clk_sys) disable iff (!rst_l)
    (fall && tap == SH_DR && st_r.ir == SBST_IR_IDCODE)
      |=> st_r.tdo == $past(st_r.id_sh[0]))
    else $error("identification bit not on data output");

  id_shift_a: assert property (
    @(posedge clk_sys) disable iff (!rst_l)
    sh_dr_s |=> st_r.id_sh[SBST_ID_W-2:0]
      == $past(st_r.id_sh[SBST_ID_W-1:1]))
    else $error("identification word did not shift");

  bsr_path_a: assert property (
    @(posedge clk_sys) disable iff (!rst_l)
    (fall && tap == SH_DR && is_bsr) |=> st_r.tdo == $past(st_r.bsr_sh[0]))
    else $error("boundary bit not on data output");

  bsr_shift_a: assert property (
    @(posedge clk_sys) disable iff (!rst_l)
    (sh_dr_s ##0 is_bsr) |=> st_r.bsr_sh == {$past(st_r.s2.tdi),
      $past(st_r.bsr_sh[SBST_BSR_W-1:1])})
    else $error("boundary register did not shift");

  pin_cap_a: assert property (
    @(posedge clk_sys) disable iff (!rst_l)
    (cap_dr_s ##0 is_bsr) |=> st_r.bsr_sh[SBST_NPIN-1:0] == $past(pin_in))
    else $error("pin values not captured");

  oe_cap_a: assert property (
    @(posedge clk_sys) disable iff (!rst_l)
    (cap_dr_s ##0 is_bsr) |=> st_r.bsr_sh[SBST_OE_BIT]
      == $past(st_r.bsr_up[SBST_OE_BIT]))
    else $error("enable cell not captured");

  sampz_keep_a: assert property (
    @(posedge clk_sys) disable iff (!rst_l)
    (upd_dr_s ##0 st_r.ir == SBST_IR_SAMPZ) |=> $stable(st_r.bsr_up))
    else $error("latches changed under sample high-Z");

  preload_a: assert property (
    @(posedge clk_sys) disable iff (!rst_l)
    (upd_dr_s ##0 st_r.ir == SBST_IR_SAMPLE)
      |=> st_r.bsr_up == $past(st_r.bsr_sh))
    else $error("preload pattern not latched");

  oe_latch_a: assert property (
    @(posedge clk_sys) disable iff (!rst_l)
    (upd_dr_s ##0 st_r.ir == SBST_IR_EXTEST) |=> st_r.bsr_up[SBST_OE_BIT]
      == $past(st_r.bsr_sh[SBST_OE_BIT]))
    else $error("enable cell not latched at Update-DR");

  up_hold_a: assert property (
    @(posedge clk_sys) disable iff (!rst_l)
    !(rise && tap == UPD_DR) && tap != TLR |=> $stable(st_r.bsr_up))
    else $error("latches changed outside Update-DR");

  byp_cap_a: assert property (
    @(posedge clk_sys) disable iff (!rst_l)
    cap_dr_s |=> !st_r.byp)
    else $error("bypass bit not cleared at capture");

  byp_shift_a: assert property (
    @(posedge clk_sys) disable iff (!rst_l)
    sh_dr_s |=> st_r.byp == $past(st_r.s2.tdi))
    else $error("bypass bit did not take data input");

  oe_track_a: assert property (
    @(posedge clk_sys) disable iff (!rst_l)
    fall |=> st_r.tdo_oe == $past(tap == SH_IR || tap == SH_DR))
    else $error("data output enable wrong after falling edge");

  oe_hold_a: assert property (
    @(posedge clk_sys) disable iff (!rst_l)
    !fall |=> $stable(st_r.tdo_oe))
    else $error("data output enable changed off a falling edge");

  free_pins_a: assert property (
    @(posedge clk_sys) disable iff (!rst_l)
    st_r.ir != SBST_IR_EXTEST && st_r.ir != SBST_IR_SAMPZ
      |-> pin_out == sys_out && pin_out_oe == sys_out_oe)
    else $error("system outputs not passed through");

  legal_ir_a: assert property (
    @(posedge clk_sys) disable iff (!rst_l)
    st_r.ir != 3'h3 && st_r.ir != 3'h5 && st_r.ir != 3'h6)
    else $error("reserved instruction became current");
endmodule : sbst_tap
`default_nettype wire
